/* File: sfm_chk.sv */
// Checker for the serial format mode decode block.
// Assumes it is bound into sfm_decode and sees only its ports.
`timescale 1ns/1ps

module sfm_chk (
    input wire logic       aclk,              // Clock.
    input wire logic       aresetn,           // Reset, low.
    input wire logic       s_axi_awvalid,     // Bus.
    input wire logic       s_axi_awready,     // Bus.
    input wire logic       s_axi_wvalid,      // Bus.
    input wire logic       s_axi_wready,      // Bus.
    input wire logic       s_axi_bvalid,      // Bus.
    input wire logic       s_axi_arvalid,     // Bus.
    input wire logic       s_axi_arready,     // Bus.
    input wire logic       s_axi_rvalid,      // Bus.
    input wire logic       multiproc_on,      // Mode.
    input wire logic       parity_enable,     // Mode.
    input wire logic       mode_clocked,      // Mode.
    input wire logic       mode_card,         // Mode.
    input wire logic       handset_timing,    // Card.
    input wire logic       card_clk_ctrl_en,  // Card.
    input wire logic [7:0] transmit_finished_flag_advance_x10,  // Card.
    input wire logic [8:0] etu_clocks         // Card.
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_rd_resp; s_rd_taken |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_mp_par; multiproc_on |-> !parity_enable; endproperty
    a_mp_par: assert property (p_mp_par) else $error("parity on with multiprocessor");
    property p_mp_async; multiproc_on |-> !mode_clocked && !mode_card; endproperty
    a_mp_async: assert property (p_mp_async) else $error("multiprocessor outside async");
    property p_hs_clk; card_clk_ctrl_en == handset_timing; endproperty
    a_hs_clk: assert property (p_hs_clk) else $error("clock control wrong");
    property p_transmit_finished_flag; transmit_finished_flag_advance_x10 == (handset_timing ? 8'h6e : 8'h00); endproperty
    a_transmit_finished_flag: assert property (p_transmit_finished_flag) else $error("advance wrong");
    property p_etu_norm; !mode_card |-> etu_clocks == 9'h020; endproperty
    a_etu_norm: assert property (p_etu_norm) else $error("time unit outside card");
    property p_etu_set; etu_clocks inside {9'h020, 9'h040, 9'h174, 9'h100}; endproperty
    a_etu_set: assert property (p_etu_set) else $error("time unit off table");
endmodule : sfm_chk

bind sfm_decode sfm_chk chk_u (.*);

/* File: sfm_decode.sv */
// Mode-register decode for the serial unit, reached over AXI4-Lite.
// Assumes one clock aclk at 40 MHz and synchronous active-low reset aresetn.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sfm_params.svh"

module sfm_decode (
    input  wire logic        aclk,              // System clock.
    input  wire logic        aresetn,           // Synchronous reset, active low.
    input  wire logic [7:0]  s_axi_awaddr,      // Write address.
    input  wire logic        s_axi_awvalid,     // Write address valid.
    output logic             s_axi_awready,     // Write address ready.
    input  wire logic [31:0] s_axi_wdata,       // Write data.
    input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes.
    input  wire logic        s_axi_wvalid,      // Write data valid.
    output logic             s_axi_wready,      // Write data ready.
    output logic [1:0]       s_axi_bresp,       // Write response.
    output logic             s_axi_bvalid,      // Write response valid.
    input  wire logic        s_axi_bready,      // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,      // Read address.
    input  wire logic        s_axi_arvalid,     // Read address valid.
    output logic             s_axi_arready,     // Read address ready.
    output logic [31:0]      s_axi_rdata,       // Read data.
    output logic [1:0]       s_axi_rresp,       // Read response.
    output logic             s_axi_rvalid,      // Read data valid.
    input  wire logic        s_axi_rready,      // Read data ready.
    input  wire logic        tx_char_done,      // Transmitter finished a character, one-cycle pulse.
    input  wire logic        rx_parity_error,   // Receiver parity mismatch, one-cycle pulse.
    output logic             baud_tick,         // Prescaled enable pulse to the baud-rate counter.
    output logic             mode_clocked,      // Clocked synchronous operation.
    output logic             mode_card,         // Card layout in force.
    output logic             multiproc_on,      // Multiprocessor function on.
    output logic             parity_enable,     // Parity added and checked.
    output logic             parity_odd,        // Odd parity when parity enabled.
    output logic             block_transfer,    // Block transfer mode.
    output logic             handset_timing,    // Handset timing mode.
    output logic             card_clk_ctrl_en,  // Card clock output control available.
    output logic [7:0]       transmit_finished_flag_advance_x10,  // Transmit-end advance in tenths of a time unit.
    output logic [8:0]       etu_clocks,        // Basic clocks per transferred bit.
    output logic             irq                // Interrupt, level, active high.
);

    // ------------------------------------------------------------------------
    // Registers and bus state
    // ------------------------------------------------------------------------
    logic [7:0]                 serial_format_reg;
    logic [7:0]                 next_serial_format_reg;
    logic                       card_mode_select;
    logic                       next_card_mode_select;
    logic [`SFM_IRQ_WIDTH-1:0]  irq_status;
    logic [`SFM_IRQ_WIDTH-1:0]  next_irq_status;
    logic [`SFM_IRQ_WIDTH-1:0]  irq_mask;
    logic [`SFM_IRQ_WIDTH-1:0]  next_irq_mask;
    logic [`SFM_IRQ_WIDTH-1:0]  events;

    logic                       aw_held;
    logic                       next_aw_held;
    logic [7:0]                 aw_addr;
    logic [7:0]                 next_aw_addr;
    logic                       w_held;
    logic                       next_w_held;
    logic [31:0]                w_data;
    logic [31:0]                next_w_data;
    logic [3:0]                 w_strb;
    logic [3:0]                 next_w_strb;
    logic                       next_bvalid;
    logic [1:0]                 next_bresp;
    logic                       do_write;

    sfm_pkg::sfm_rd_state_type  rd_state;
    sfm_pkg::sfm_rd_state_type  next_rd_state;
    logic [31:0]                next_rdata;
    logic [1:0]                 next_rresp;
    logic [31:0]                read_value;
    logic                       read_hit;

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    sfm_pkg::sfm_mode_type      mode;
    sfm_pkg::sfm_parity_type    parity;
    logic                       next_multiproc_on;
    logic                       next_parity_enable;
    logic                       next_parity_odd;
    logic                       next_block_transfer;
    logic                       next_handset_timing;
    logic [7:0]                 next_transmit_finished_flag_advance;
    logic [8:0]                 next_etu_clocks;
    logic                       prescale_tick;

    always_comb begin
        if (card_mode_select) begin
            mode = sfm_pkg::sfm_mode_card;
        end else if (serial_format_reg[`SFM_BIT_COMM_MODE]) begin
            mode = sfm_pkg::sfm_mode_clocked;
        end else begin
            mode = sfm_pkg::sfm_mode_async;
        end
        next_multiproc_on   = 1'b0;
        next_block_transfer = 1'b0;
        next_handset_timing = 1'b0;
        next_transmit_finished_flag_advance   = 8'h00;
        next_etu_clocks     = `SFM_ETU_CLK_32;
        parity              = sfm_pkg::sfm_parity_none;
        unique case (mode)
            sfm_pkg::sfm_mode_async: begin
                next_multiproc_on = serial_format_reg[`SFM_BIT_MULTIPROC];
                if (!next_multiproc_on && serial_format_reg[`SFM_BIT_PARITY_ON]) begin
                    parity = serial_format_reg[`SFM_BIT_PARITY_ODD] ? sfm_pkg::sfm_parity_odd
                                                                     : sfm_pkg::sfm_parity_even;
                end
            end
            sfm_pkg::sfm_mode_clocked: begin
                parity = sfm_pkg::sfm_parity_none;
            end
            sfm_pkg::sfm_mode_card: begin
                // Software is expected to keep parity on here; the bit is still honoured as written.
                if (serial_format_reg[`SFM_BIT_PARITY_ON]) begin
                    parity = serial_format_reg[`SFM_BIT_PARITY_ODD] ? sfm_pkg::sfm_parity_odd
                                                                     : sfm_pkg::sfm_parity_even;
                end
                next_block_transfer = serial_format_reg[`SFM_BIT_BLOCK];
                next_handset_timing = serial_format_reg[`SFM_BIT_HANDSET];
                next_transmit_finished_flag_advance   = next_handset_timing ? `SFM_TRANSMIT_FINISHED_FLAG_ADVANCE_X10 : 8'h00;
                unique case (serial_format_reg[`SFM_BIT_ETU_HI:`SFM_BIT_ETU_LO])
                    2'h0: next_etu_clocks = `SFM_ETU_CLK_32;
                    2'h1: next_etu_clocks = `SFM_ETU_CLK_64;
                    2'h2: next_etu_clocks = `SFM_ETU_CLK_372;
                    2'h3: next_etu_clocks = `SFM_ETU_CLK_256;
                endcase
            end
            default: begin
                parity = sfm_pkg::sfm_parity_none;
            end
        endcase
        next_parity_enable = (parity != sfm_pkg::sfm_parity_none);
        next_parity_odd    = (parity == sfm_pkg::sfm_parity_odd);
    end

    sfm_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .select  (serial_format_reg[`SFM_BIT_PSC_HI:`SFM_BIT_PSC_LO]),
        .tick    (prescale_tick)
    );

    // ------------------------------------------------------------------------
    // Write channel and register updates
    // ------------------------------------------------------------------------
    assign events = {rx_parity_error & parity_enable, tx_char_done, 1'b0};

    always_comb begin
        next_aw_held          = aw_held;
        next_aw_addr          = aw_addr;
        next_w_held           = w_held;
        next_w_data           = w_data;
        next_w_strb           = w_strb;
        next_bvalid           = s_axi_bvalid;
        next_bresp            = s_axi_bresp;
        next_serial_format_reg = serial_format_reg;
        next_card_mode_select = card_mode_select;
        next_irq_mask         = irq_mask;
        next_irq_status       = irq_status;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = 2'h0;
            if (w_strb[0]) begin
                unique case (aw_addr)
                    `SFM_ADDR_FORMAT:     next_serial_format_reg = w_data[7:0];
                    `SFM_ADDR_CARD_CTRL:  next_card_mode_select = w_data[`SFM_BIT_CARD_MODE];
                    `SFM_ADDR_IRQ_STATUS: next_irq_status = irq_status & ~w_data[`SFM_IRQ_WIDTH-1:0];
                    `SFM_ADDR_IRQ_MASK:   next_irq_mask = w_data[`SFM_IRQ_WIDTH-1:0];
                    `SFM_ADDR_EVENT_IN, `SFM_ADDR_DECODED: next_bresp = 2'h0;
                    default:              next_bresp = 2'h2;
                endcase
            end else if (!(aw_addr inside {`SFM_ADDR_FORMAT, `SFM_ADDR_CARD_CTRL, `SFM_ADDR_IRQ_STATUS,
                                           `SFM_ADDR_IRQ_MASK, `SFM_ADDR_EVENT_IN, `SFM_ADDR_DECODED})) begin
                next_bresp = 2'h2;
            end
        end
        // A new event wins over a clear in the same cycle.
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held           <= 1'b0;
            aw_addr           <= 8'h00;
            w_held            <= 1'b0;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= 2'h0;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            serial_format_reg <= `SFM_FORMAT_RESET;
            card_mode_select  <= 1'b0;
            irq_status        <= `SFM_IRQ_RESET;
            irq_mask          <= `SFM_IRQ_RESET;
        end else begin
            aw_held           <= next_aw_held;
            aw_addr           <= next_aw_addr;
            w_held            <= next_w_held;
            w_data            <= next_w_data;
            w_strb            <= next_w_strb;
            s_axi_bvalid      <= next_bvalid;
            s_axi_bresp       <= next_bresp;
            s_axi_awready     <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready      <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
            serial_format_reg <= next_serial_format_reg;
            card_mode_select  <= next_card_mode_select;
            irq_status        <= next_irq_status;
            irq_mask          <= next_irq_mask;
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    always_comb begin
        read_hit   = 1'b1;
        read_value = 32'h0000_0000;
        unique case (s_axi_araddr)
            `SFM_ADDR_FORMAT:     read_value = {24'h00_0000, serial_format_reg};
            `SFM_ADDR_CARD_CTRL:  read_value = {31'h0000_0000, card_mode_select};
            `SFM_ADDR_IRQ_STATUS: read_value = {29'h0000_0000, irq_status};
            `SFM_ADDR_IRQ_MASK:   read_value = {29'h0000_0000, irq_mask};
            `SFM_ADDR_EVENT_IN:   read_value = 32'h0000_0000;
            `SFM_ADDR_DECODED:    read_value = {16'h0000, etu_clocks, block_transfer, handset_timing,
                                                parity_odd, parity_enable, multiproc_on, mode_card, mode_clocked};
            default:              read_hit = 1'b0;
        endcase
        next_rd_state = rd_state;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        unique case (rd_state)
            sfm_pkg::sfm_rd_idle: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_rd_state = sfm_pkg::sfm_rd_resp;
                    next_rdata    = read_value;
                    next_rresp    = read_hit ? 2'h0 : 2'h2;
                end
            end
            sfm_pkg::sfm_rd_resp: begin
                if (s_axi_rready) begin
                    next_rd_state = sfm_pkg::sfm_rd_idle;
                end
            end
            default: next_rd_state = sfm_pkg::sfm_rd_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state      <= sfm_pkg::sfm_rd_idle;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            rd_state      <= next_rd_state;
            s_axi_arready <= (next_rd_state == sfm_pkg::sfm_rd_idle) && !(s_axi_arvalid && s_axi_arready);
            s_axi_rvalid  <= (next_rd_state == sfm_pkg::sfm_rd_resp);
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_tick        <= 1'b0;
            mode_clocked     <= 1'b0;
            mode_card        <= 1'b0;
            multiproc_on     <= 1'b0;
            parity_enable    <= 1'b0;
            parity_odd       <= 1'b0;
            block_transfer   <= 1'b0;
            handset_timing   <= 1'b0;
            card_clk_ctrl_en <= 1'b0;
            transmit_finished_flag_advance_x10 <= 8'h00;
            etu_clocks       <= `SFM_ETU_CLK_32;
            irq              <= 1'b0;
        end else begin
            baud_tick        <= prescale_tick;
            mode_clocked     <= (mode == sfm_pkg::sfm_mode_clocked);
            mode_card        <= (mode == sfm_pkg::sfm_mode_card);
            multiproc_on     <= next_multiproc_on;
            parity_enable    <= next_parity_enable;
            parity_odd       <= next_parity_odd;
            block_transfer   <= next_block_transfer;
            handset_timing   <= next_handset_timing;
            card_clk_ctrl_en <= next_handset_timing;
            transmit_finished_flag_advance_x10 <= next_transmit_finished_flag_advance;
            etu_clocks       <= next_etu_clocks;
            irq              <= |(next_irq_status & next_irq_mask);
        end
    end

endmodule : sfm_decode

/* File: sfm_decode_tb.sv */
// Testbench for the serial format mode decode block.
// Assumes the checker is bound and the station model drives the event inputs.
`timescale 1ns/1ps
`define CHK(a,b) begin n_compared++; if ((a)!==(b)) begin error_cnt++; $display("mismatch t=%0t got=%0h exp=%0h",$time,a,b); end end

module sfm_decode_tb;
    logic aclk = 0, aresetn = 0, send_done = 0, send_bad = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, transmit_finished_flag_advance_x10;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_char_done, rx_parity_error;
    logic baud_tick, mode_clocked, mode_card, multiproc_on, parity_enable, parity_odd, block_transfer;
    logic handset_timing, card_clk_ctrl_en, irq;
    logic [8:0] etu_clocks;
    logic [8:0] tbl [4] = '{9'h020, 9'h040, 9'h174, 9'h100};
    int error_cnt = 0, n_compared = 0, cyc = 0, n;
    sfm_decode dut_u (.*);
    sfm_station stn_u (.aclk(aclk), .aresetn(aresetn), .send_done(send_done), .send_bad(send_bad),
                       .tx_char_done(tx_char_done), .rx_parity_error(rx_parity_error));
    always #12.5 aclk = ~aclk;
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin error_cnt++; wrap_up(); end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
        repeat (2) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(posedge aclk); if (s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    endtask : rd
    task automatic pulse(input logic bad);
        @(posedge aclk); if (bad) send_bad <= 1; else send_done <= 1;
        @(posedge aclk); send_bad <= 0; send_done <= 0;
        repeat (3) @(posedge aclk);
    endtask : pulse
    task automatic t_async;
        rd(8'h00); `CHK(d, 32'h0) `CHK(etu_clocks, 9'h020)
        wr(8'h00, 32'h34); `CHK(multiproc_on, 1'b1) `CHK(parity_enable, 1'b0)
        wr(8'h00, 32'h30); `CHK(parity_enable, 1'b1) `CHK(parity_odd, 1'b1)
        wr(8'h00, 32'h20); `CHK(parity_odd, 1'b0) `CHK(r, 2'b00)
        wr(8'h00, 32'ha4); `CHK(mode_clocked, 1'b1) `CHK(multiproc_on, 1'b0)
        rd(8'h00); `CHK(d, 32'ha4)
    endtask : t_async
    task automatic t_psc;
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, i);
            do @(posedge aclk); while (!baud_tick);
            n = 0;
            do begin @(posedge aclk); n++; end while (!baud_tick);
            `CHK(n, 1 << (2 * i))
        end
    endtask : t_psc
    task automatic t_card;
        wr(8'h04, 32'h1); `CHK(mode_card, 1'b1)
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h20 | (i << 2)); `CHK(etu_clocks, tbl[i])
        end
        wr(8'h00, 32'he0); `CHK(transmit_finished_flag_advance_x10, 8'h6e) `CHK(card_clk_ctrl_en, 1'b1)
        `CHK(block_transfer, 1'b1) `CHK(parity_enable, 1'b1) `CHK(handset_timing, 1'b1)
        rd(8'h14); `CHK(d, 32'h106a)
    endtask : t_card
    task automatic t_irq;
        wr(8'h0c, 32'h6); pulse(0); `CHK(irq, 1'b1)
        rd(8'h08); `CHK(d, 32'h2)
        wr(8'h08, 32'h2); `CHK(irq, 1'b0)
        pulse(1); rd(8'h08); `CHK(d, 32'h4)
        wr(8'h08, 32'h4); wr(8'h04, 32'h0); wr(8'h00, 32'h0);
        pulse(1); rd(8'h08); `CHK(d, 32'h0)
        wr(8'h0c, 32'h0); pulse(0); `CHK(irq, 1'b0)
        wr(8'h18, 32'h0); `CHK(r, 2'b10)
        rd(8'h18); `CHK(r, 2'b10) `CHK(d, 32'h0)
        s_axi_wstrb <= 4'h0;
        wr(8'h00, 32'hff);
        s_axi_wstrb <= 4'hf;
        rd(8'h00); `CHK(d, 32'h0)
    endtask : t_irq
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        t_async(); t_psc(); t_card(); t_irq();
        wrap_up();
    end
endmodule : sfm_decode_tb

/* File: sfm_params.svh */
// Constants for the serial format mode decode block: register offsets, field positions, reset values and timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SFM_ADDR_FORMAT      8'h00
`define SFM_ADDR_CARD_CTRL   8'h04
`define SFM_ADDR_IRQ_STATUS  8'h08
`define SFM_ADDR_IRQ_MASK    8'h0c
`define SFM_ADDR_EVENT_IN    8'h10
`define SFM_ADDR_DECODED     8'h14

// ----------------------------------------------------------------------------
// Field positions, format register and card control register
// ----------------------------------------------------------------------------
`define SFM_BIT_COMM_MODE    7
`define SFM_BIT_HANDSET      7
`define SFM_BIT_BLOCK        6
`define SFM_BIT_PARITY_ON    5
`define SFM_BIT_PARITY_ODD   4
`define SFM_BIT_MULTIPROC    2
`define SFM_BIT_ETU_HI       3
`define SFM_BIT_ETU_LO       2
`define SFM_BIT_PSC_HI       1
`define SFM_BIT_PSC_LO       0
`define SFM_BIT_CARD_MODE    0

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define SFM_FORMAT_RESET     8'h00
`define SFM_IRQ_WIDTH        3
`define SFM_IRQ_RESET        3'h0

// ----------------------------------------------------------------------------
// Prescaler ratios, time-unit clock counts and transmit-end advance
// ----------------------------------------------------------------------------
`define SFM_PSC_DIV1         7'h01
`define SFM_PSC_DIV4         7'h04
`define SFM_PSC_DIV16        7'h10
`define SFM_PSC_DIV64        7'h40
`define SFM_ETU_CLK_32       9'h020
`define SFM_ETU_CLK_64       9'h040
`define SFM_ETU_CLK_372      9'h174
`define SFM_ETU_CLK_256      9'h100
`define SFM_TRANSMIT_FINISHED_FLAG_ADVANCE_X10 8'h6e

`endif

/* File: sfm_pkg.sv */
// Types shared by the serial format mode decode block.
// Assumes sfm_params.svh is on the include path.
`include "sfm_params.svh"

package sfm_pkg;

    // ------------------------------------------------------------------------
    // Communication mode, parity kind and read-channel state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        sfm_mode_async,
        sfm_mode_clocked,
        sfm_mode_card
    } sfm_mode_type;

    typedef enum logic [1:0] {
        sfm_parity_none,
        sfm_parity_even,
        sfm_parity_odd
    } sfm_parity_type;

    typedef enum logic [1:0] {
        sfm_rd_idle,
        sfm_rd_resp
    } sfm_rd_state_type;

endpackage : sfm_pkg

/* File: sfm_prescaler.sv */
// Free-running prescaler that issues one-cycle enable pulses for the baud-rate generator.
// Assumes a single clock aclk and synchronous active-low reset aresetn.
`timescale 1ns/1ps
`include "sfm_params.svh"

module sfm_prescaler (
    input  wire logic       aclk,      // System clock.
    input  wire logic       aresetn,   // Synchronous reset, active low.
    input  wire logic [1:0] select,    // Ratio select 0..3.
    output logic            tick       // One-cycle enable pulse.
);

    logic [6:0] count;
    logic [6:0] next_count;
    logic [6:0] ratio;
    logic       next_tick;

    always_comb begin
        unique case (select)
            2'h0: ratio = `SFM_PSC_DIV1;
            2'h1: ratio = `SFM_PSC_DIV4;
            2'h2: ratio = `SFM_PSC_DIV16;
            2'h3: ratio = `SFM_PSC_DIV64;
        endcase
        if (count >= ratio - 7'h01) begin
            next_count = 7'h00;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 7'h01;
            next_tick  = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 7'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule : sfm_prescaler

/* File: sfm_station.sv */
// Remote station model: turns bench commands into one-cycle event pulses.
// Assumes the bench raises each command for one cycle.
`timescale 1ns/1ps

module sfm_station (
    input  wire logic aclk,            // Clock.
    input  wire logic aresetn,         // Reset, low.
    input  wire logic send_done,       // Character sent.
    input  wire logic send_bad,        // Bad parity seen.
    output logic      tx_char_done,    // Event pulse.
    output logic      rx_parity_error  // Event pulse.
);
    logic next_done;
    logic next_bad;
    always_comb begin
        next_done = aresetn & send_done;
        next_bad  = aresetn & send_bad;
    end
    always_ff @(posedge aclk) begin
        tx_char_done    <= next_done;
        rx_parity_error <= next_bad;
    end
endmodule : sfm_station
